/* hdl/sps_regs.sv */
// serial controller: status, mode, diagnostic state and rate divider
// assumes synchronous pins and a one-cycle strobe register port
//
// Our own choice: the plain strobed port.
`timescale 1ns/10ps
`default_nettype none

module sps_regs
    import sps_pkg::*;
(
    input wire logic clk,
    input wire logic srst,
    input wire sps_bus_req_t req,
    output logic [7:0] rdata,
    input wire logic sck_i,
    output logic sck_o,
    output logic sck_oe,
    input wire logic mosi_i,
    output logic mosi_o,
    output logic mosi_oe,
    input wire logic miso_i,
    output logic miso_o,
    output logic miso_oe,
    input wire logic ss_n_i,
    output logic ss_n_o,
    output logic ss_n_oe,
    output logic irq_o
);

    // ========================================================
    // storage
    sps_ctrl_t ctrl_ff;
    sps_mode_t mode_ff;
    sps_state_t state_ff;
    sps_state_t nxt_state;
    logic [7:0] rate_hi_ff;
    logic [7:0] rate_lo_ff;
    logic [7:0] rdata_ff;
    logic [7:0] shift_ff;
    logic [7:0] hold_ff;
    logic [15:0] cnt_ff;
    logic [2:0] bits_ff;
    logic irq_ff;
    logic ovr_ff;
    logic col_ff;
    logic abt_ff;
    logic sample_ff;
    logic out_ff;
    logic out_pend_ff;
    logic sck_ff;
    logic sck_prev_ff;
    logic ss_prev_ff;
    logic irq_out_ff;

    // ========================================================
    // decode and control terms
    logic en;
    logic master;
    logic slave;
    logic busy;
    logic wr_data;
    logic wr_ctrl;
    logic wr_stat;
    logic wr_mode;
    logic fault;
    logic start;
    logic timer_mode;
    logic cnt_run;
    logic tick;
    logic [15:0] reload_m1;
    logic sck_lvl;
    logic slave_sel;
    logic lead_edge;
    logic trail_edge;
    logic ss_fall;
    logic ss_rise;
    logic slave_abort;
    logic shift_tick;
    logic output_tick;
    logic sample_en;
    logic last_bit;
    logic done_evt;
    sps_status_t status;

    assign en = ctrl_ff.block_enable;
    assign master = en && ctrl_ff.master_select;
    assign slave = en && !ctrl_ff.master_select;
    assign busy = (state_ff != SPS_IDLE);
    assign wr_data = req.wr && (req.addr == SPS_ADDR_DATA);
    assign wr_ctrl = req.wr && (req.addr == SPS_ADDR_CTRL);
    assign wr_stat = req.wr && (req.addr == SPS_ADDR_STAT);
    assign wr_mode = req.wr && (req.addr == SPS_ADDR_MODE);
    // fault only when the select pin is an input
    assign fault = master && !mode_ff.select_direction && !ss_n_i;
    assign start = master && wr_data && !busy && !fault;
    assign timer_mode = !en && ctrl_ff.timer_irq_enable;
    assign cnt_run = timer_mode ||
        (master && (state_ff == SPS_M_LEAD || state_ff == SPS_M_TRAIL));
    // reload of zero wraps to ffff, i.e. 65536 cycles per tick
    assign reload_m1 = 16'({rate_hi_ff, rate_lo_ff} - SPS_ONE);
    assign tick = cnt_run && (cnt_ff == 16'h0000);

    assign sck_lvl = sck_i ^ ctrl_ff.clock_polarity;
    assign slave_sel = slave && !ss_n_i;
    assign lead_edge = slave_sel && sck_lvl && !sck_prev_ff;
    assign trail_edge = slave_sel && !sck_lvl && sck_prev_ff;
    assign ss_fall = slave && !ss_n_i && ss_prev_ff;
    assign ss_rise = slave && ss_n_i && !ss_prev_ff;
    assign slave_abort = ss_rise && (state_ff == SPS_S_ACTIVE) &&
        (bits_ff != 3'h0);

    // length code 000 wraps the count to eight bits
    assign last_bit = (3'(bits_ff + 3'h1) == mode_ff.char_length);
    assign shift_tick = (state_ff == SPS_M_TRAIL && tick && !fault) ||
        (state_ff == SPS_S_ACTIVE && trail_edge);
    assign sample_en = (state_ff == SPS_M_LEAD && tick) ||
        (state_ff == SPS_S_ACTIVE && lead_edge);
    assign done_evt = shift_tick && last_bit;
    assign output_tick = out_pend_ff;

    // ========================================================
    // state machine
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            SPS_IDLE: begin
                if (start) begin
                    nxt_state = SPS_M_LEAD;
                end else if (ss_fall) begin
                    nxt_state = SPS_S_ACTIVE;
                end
            end
            SPS_M_LEAD: begin
                if (!master || fault) begin
                    nxt_state = SPS_IDLE;
                end else if (tick) begin
                    nxt_state = SPS_M_TRAIL;
                end
            end
            SPS_M_TRAIL: begin
                if (!master || fault) begin
                    nxt_state = SPS_IDLE;
                end else if (tick) begin
                    nxt_state = last_bit ? SPS_IDLE : SPS_M_LEAD;
                end
            end
            SPS_S_ACTIVE: begin
                if (!slave_sel) begin
                    nxt_state = SPS_IDLE;
                end
            end
            default: begin
                nxt_state = SPS_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            state_ff <= SPS_IDLE;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // ========================================================
    // rate divider, also the disabled-mode timer
    always_ff @(posedge clk) begin
        if (srst) begin
            cnt_ff <= SPS_CNT_RST;
        end else if (!cnt_run || tick) begin
            cnt_ff <= reload_m1;
        end else begin
            cnt_ff <= cnt_ff - SPS_ONE;
        end
    end

    // ========================================================
    // bit counter and clock levels
    always_ff @(posedge clk) begin
        if (srst || state_ff == SPS_IDLE) begin
            bits_ff <= 3'h0;
        end else if (shift_tick) begin
            bits_ff <= last_bit ? 3'h0 : 3'(bits_ff + 3'h1);
        end
    end

    always_ff @(posedge clk) begin
        if (srst || !master || state_ff == SPS_IDLE) begin
            sck_ff <= 1'b0;
        end else if (tick) begin
            sck_ff <= (state_ff == SPS_M_LEAD);
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            sck_prev_ff <= 1'b0;
            ss_prev_ff <= 1'b1;
        end else begin
            sck_prev_ff <= sck_lvl;
            ss_prev_ff <= ss_n_i;
        end
    end

    // ========================================================
    // shift path
    always_ff @(posedge clk) begin
        if (srst) begin
            sample_ff <= 1'b0;
        end else if (sample_en) begin
            sample_ff <= master ? miso_i : mosi_i;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            shift_ff <= SPS_DATA_RST;
            hold_ff <= SPS_DATA_RST;
        end else if (wr_data && !busy) begin
            shift_ff <= req.wdata;
            hold_ff <= req.wdata;
        end else if (slave_abort) begin
            shift_ff <= hold_ff;
        end else if (shift_tick) begin
            shift_ff <= {shift_ff[6:0], sample_ff};
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            out_pend_ff <= 1'b0;
        end else begin
            out_pend_ff <= start || shift_tick || ss_fall || slave_abort;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            out_ff <= 1'b0;
        end else if (output_tick) begin
            out_ff <= shift_ff[7];
        end
    end

    // ========================================================
    // control, mode and rate registers
    always_ff @(posedge clk) begin
        if (srst) begin
            ctrl_ff <= SPS_CTRL_RST;
        end else if (wr_ctrl) begin
            ctrl_ff <= req.wdata & 8'hEB;
        end else if (wr_stat && req.wdata[7]) begin
            ctrl_ff.force_interrupt <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            mode_ff <= SPS_MODE_RST;
        end else if (wr_mode) begin
            mode_ff <= {2'b00, req.wdata[5:0]};
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            rate_hi_ff <= SPS_RATE_RST;
            rate_lo_ff <= SPS_RATE_RST;
        end else if (req.wr && req.addr == SPS_ADDR_RATE_HI) begin
            rate_hi_ff <= req.wdata;
        end else if (req.wr && req.addr == SPS_ADDR_RATE_LO) begin
            rate_lo_ff <= req.wdata;
        end
    end

    // ========================================================
    // status flags: set wins over a same-cycle clear
    always_ff @(posedge clk) begin
        if (srst || !en) begin
            irq_ff <= 1'b0;
            ovr_ff <= 1'b0;
            col_ff <= 1'b0;
            abt_ff <= 1'b0;
        end else begin
            irq_ff <= (wr_ctrl && req.wdata[6]) || done_evt ||
                slave_abort || (irq_ff && !(wr_stat && req.wdata[7]));
            ovr_ff <= (wr_data && busy) ||
                (ovr_ff && !(wr_stat && req.wdata[6]));
            col_ff <= fault ||
                (col_ff && !(wr_stat && req.wdata[5]));
            abt_ff <= slave_abort ||
                (abt_ff && !(wr_stat && req.wdata[4]));
        end
    end

    always_comb begin
        status = '0;
        status.irq = irq_ff;
        status.write_overrun_flag = ovr_ff;
        status.collision = col_ff;
        status.slave_abort_flag = abt_ff;
        status.transfer_active = en && busy;
        status.select_sense = !slave || ss_n_i;
    end

    // ========================================================
    // interrupt request, timer timeout bypasses the pending flag
    always_ff @(posedge clk) begin
        if (srst) begin
            irq_out_ff <= 1'b0;
        end else begin
            irq_out_ff <= (ctrl_ff.irq_enable && irq_ff) ||
                (timer_mode && tick);
        end
    end

    // ========================================================
    // read port
    always_ff @(posedge clk) begin
        if (srst || !req.rd) begin
            rdata_ff <= 8'h00;
        end else begin
            case (req.addr)
                SPS_ADDR_DATA: rdata_ff <= shift_ff;
                SPS_ADDR_CTRL: rdata_ff <= ctrl_ff;
                SPS_ADDR_STAT: rdata_ff <= status;
                SPS_ADDR_MODE: rdata_ff <= mode_ff;
                SPS_ADDR_LIVE_COUNTER_READBACK: begin
                    rdata_ff <= {shift_tick, output_tick, 4'h0,
                        state_ff};
                end
                SPS_ADDR_RATE_HI: begin
                    rdata_ff <= mode_ff.live_counter_readback ?
                        cnt_ff[15:8] : rate_hi_ff;
                end
                SPS_ADDR_RATE_LO: begin
                    rdata_ff <= mode_ff.live_counter_readback ?
                        cnt_ff[7:0] : rate_lo_ff;
                end
                default: rdata_ff <= 8'h00;
            endcase
        end
    end

    // ========================================================
    // pins
    assign rdata = rdata_ff;
    assign sck_o = sck_ff ^ ctrl_ff.clock_polarity;
    assign sck_oe = master;
    assign mosi_o = out_ff;
    assign mosi_oe = master;
    assign miso_o = out_ff;
    assign miso_oe = slave_sel;
    assign ss_n_o = mode_ff.select_level;
    assign ss_n_oe = ctrl_ff.master_select &&
        mode_ff.select_direction;
    assign irq_o = irq_out_ff;

    // ========================================================
    // checks
    logic [16:0] gap_ff;
    logic seen_ff;
    always_ff @(posedge clk) begin
        if (srst || !cnt_run || tick) begin
            gap_ff <= 17'h00000;
            seen_ff <= cnt_run && tick;
        end else begin
            gap_ff <= 17'(gap_ff + 17'h00001);
        end
    end

    chk_off_clears: assert property (@(posedge clk)
        disable iff (srst) !en |=> !irq_ff && !ovr_ff && !col_ff && !abt_ff)
        else $error("status flags survive disable");
    chk_done_pending: assert property (@(posedge clk)
        disable iff (srst) en && done_evt && !wr_ctrl |=> irq_ff)
        else $error("character done did not set pending");
    chk_timer_irq: assert property (@(posedge clk)
        disable iff (srst) timer_mode && tick |=> irq_o && !irq_ff)
        else $error("timer timeout wrong");
    chk_abort_flags: assert property (@(posedge clk)
        disable iff (srst) slave_abort && !wr_ctrl |=>
        abt_ff && irq_ff ##1 out_ff == hold_ff[7])
        else $error("slave abort handling wrong");
    chk_transfer_active_read: assert property (@(posedge clk)
        disable iff (srst) req.rd && req.addr == SPS_ADDR_STAT |=>
        rdata[1] == $past(busy && en))
        else $error("transfer bit mismatch");
    chk_rate_gap: assert property (@(posedge clk)
        disable iff (srst) tick && seen_ff |-> gap_ff == {1'b0, reload_m1})
        else $error("divider tick spacing wrong");
    chk_overrun: assert property (@(posedge clk)
        disable iff (srst) en && wr_data && busy |=>
        ovr_ff && $stable(hold_ff))
        else $error("busy data write not rejected");
    chk_mode_fault: assert property (@(posedge clk)
        disable iff (srst) fault |=> col_ff && state_ff == SPS_IDLE)
        else $error("mode fault not flagged");
    chk_ss_slave: assert property (@(posedge clk)
        disable iff (srst) !ctrl_ff.master_select |-> !ss_n_oe)
        else $error("select driven in slave mode");
    chk_out_tick: assert property (@(posedge clk)
        disable iff (srst) shift_tick |=> ##1 out_ff == $past(shift_ff[7]))
        else $error("serial output not updated");

endmodule

`default_nettype wire

/* pkg/sps_pkg.sv */
// shared constants and types for the serial status, mode and rate block
// assumes a byte-wide register port with 12-bit addresses
package sps_pkg;

    // ========================================================
    // register addresses
    localparam logic [11:0] SPS_ADDR_DATA = 12'hF60;
    localparam logic [11:0] SPS_ADDR_CTRL = 12'hF61;
    localparam logic [11:0] SPS_ADDR_STAT = 12'hF62;
    localparam logic [11:0] SPS_ADDR_MODE = 12'hF63;
    localparam logic [11:0] SPS_ADDR_LIVE_COUNTER_READBACK = 12'hF64;
    localparam logic [11:0] SPS_ADDR_RATE_HI = 12'hF66;
    localparam logic [11:0] SPS_ADDR_RATE_LO = 12'hF67;

    // ========================================================
    // values after reset
    localparam logic [7:0] SPS_CTRL_RST = 8'h00;
    localparam logic [7:0] SPS_MODE_RST = 8'h00;
    localparam logic [7:0] SPS_RATE_RST = 8'hFF;
    localparam logic [7:0] SPS_DATA_RST = 8'h00;
    localparam logic [15:0] SPS_ONE = 16'h0001;
    localparam logic [15:0] SPS_CNT_RST = 16'hFFFE;

    // ========================================================
    // field layouts
    typedef struct packed {
        logic irq;
        logic write_overrun_flag;
        logic collision;
        logic slave_abort_flag;
        logic [1:0] rsvd;
        logic transfer_active;
        logic select_sense;
    } sps_status_t;

    typedef struct packed {
        logic [1:0] rsvd;
        logic live_counter_readback;
        logic [2:0] char_length;
        logic select_direction;
        logic select_level;
    } sps_mode_t;

    typedef struct packed {
        logic irq_enable;
        logic force_interrupt;
        logic timer_irq_enable;
        logic phase;
        logic clock_polarity;
        logic wire_or;
        logic master_select;
        logic block_enable;
    } sps_ctrl_t;

    typedef struct packed {
        logic [11:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } sps_bus_req_t;

    typedef enum logic [1:0] {
        SPS_IDLE,
        SPS_M_LEAD,
        SPS_M_TRAIL,
        SPS_S_ACTIVE
    } sps_state_t;

endpackage

/* sim/sps_far_slave.sv */
// far-side serial slave: shifts out a preset byte, captures what it hears
// assumes clock polarity 0, sampling on the leading edge, pins on clk
`timescale 1ns/10ps
`default_nettype none

module sps_far_slave (
    input wire logic clk,
    input wire logic sel_n,
    input wire logic sck,
    input wire logic mosi,
    input wire logic [7:0] tx,
    output logic miso,
    output logic [7:0] rx
);
    logic sck_q = 1'b0;
    logic sel_q = 1'b1;
    logic [7:0] sh = 8'h00;

    initial miso = 1'b0;
    initial rx = 8'h00;

    // ========================================================
    // shifter
    always @(posedge clk) begin
        sck_q <= sck;
        sel_q <= sel_n;
        if (sel_n) begin
            // released line toggles so no stale bit is read
            miso <= ~miso;
        end else if (sel_q) begin
            sh <= tx;
            miso <= tx[7];
        end else if (sck && !sck_q) begin
            rx <= {rx[6:0], mosi};
        end else if (!sck && sck_q) begin
            sh <= {sh[6:0], 1'b0};
            miso <= sh[6];
        end
    end
endmodule

`default_nettype wire

/* sim/test_sps_regs.sv */
// register-level test of the serial status, mode and rate block
// assumes sps_pkg and sps_regs compiled first, far slave model beside
`timescale 1ns/10ps
`default_nettype none

module test_sps_regs;
    import sps_pkg::*;

    logic clk = 1'b0;
    logic srst = 1'b1;
    sps_bus_req_t req = '0;
    logic [7:0] rdata;
    logic sck_o, sck_oe, mosi_o, mosi_oe, miso_o, miso_oe;
    logic ss_n_o, ss_n_oe, irq_o, far_miso;
    logic tb_sck = 1'b0;
    logic tb_mosi = 1'b1;
    logic tb_ss_n = 1'b1;
    logic [7:0] far_rx, v;
    logic sck_q = 1'b0;
    logic irq_q = 1'b0;
    int failures = 0;
    int checked = 0;
    int rises = 0;
    int since = 0;
    int period = 0;
    int ipulses = 0;
    int isince = 0;
    int igap = 0;
    int r0, i, n;

    wire logic sck_w = sck_oe ? sck_o : tb_sck;
    wire logic mosi_w = mosi_oe ? mosi_o : tb_mosi;
    wire logic miso_w = miso_oe ? miso_o : far_miso;
    wire logic ss_w = ss_n_oe ? ss_n_o : tb_ss_n;

    always #4 clk = ~clk;

    sps_regs dut_u (.clk(clk), .srst(srst), .req(req), .rdata(rdata),
        .sck_i(sck_w), .sck_o(sck_o), .sck_oe(sck_oe), .mosi_i(mosi_w),
        .mosi_o(mosi_o), .mosi_oe(mosi_oe), .miso_i(miso_w),
        .miso_o(miso_o), .miso_oe(miso_oe), .ss_n_i(ss_w),
        .ss_n_o(ss_n_o), .ss_n_oe(ss_n_oe), .irq_o(irq_o));

    sps_far_slave far_u (.clk(clk), .sel_n(ss_w), .sck(sck_w),
        .mosi(mosi_w), .tx(8'h3C), .miso(far_miso), .rx(far_rx));

    // ========================================================
    // edge timing monitors
    always @(posedge clk) begin
        sck_q <= sck_o;
        irq_q <= irq_o;
        since <= since + 1;
        isince <= isince + 1;
        if (sck_o && !sck_q) begin
            rises <= rises + 1;
            period <= since;
            since <= 1;
        end
        if (irq_o && !irq_q) begin
            ipulses <= ipulses + 1;
            igap <= isince;
            isince <= 1;
        end
    end

    // ========================================================
    // helpers
    task automatic wrap_up;
        $display("checks %0d, mismatches %0d", checked, failures);
        if (failures == 0 && checked > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask

    task automatic chk(input string what, input logic [15:0] seen,
                       input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            failures++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic bus_wr(input logic [11:0] a, input logic [7:0] d);
        req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk);
        req.wr <= 1'b0;
        @(posedge clk);
    endtask

    task automatic bus_rd(input logic [11:0] a, output logic [7:0] d);
        req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge clk);
        req.rd <= 1'b0;
        #1 d = rdata;
        @(posedge clk);
    endtask

    task automatic rd_chk(input logic [11:0] a, input logic [7:0] m,
                          input logic [7:0] e);
        logic [7:0] d;
        bus_rd(a, d);
        chk($sformatf("reg %h", a), 16'(d & m), 16'(e));
    endtask

    task automatic wait_idle;
        logic [7:0] s;
        int k;
        s = 8'h02;
        for (k = 0; k < 60 && s[1]; k++) bus_rd(SPS_ADDR_STAT, s);
        if (s[1]) begin
            chk("idle wait", 16'(s[1]), 16'h0000);
            wrap_up;
        end
    endtask

    // ========================================================
    // main sequence
    initial begin
        repeat (20) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        rd_chk(SPS_ADDR_STAT, 8'hFF, 8'h01);
        rd_chk(SPS_ADDR_MODE, 8'hFF, 8'h00);
        rd_chk(SPS_ADDR_LIVE_COUNTER_READBACK, 8'hFF, 8'h00);
        rd_chk(SPS_ADDR_RATE_HI, 8'hFF, 8'hFF);
        rd_chk(SPS_ADDR_RATE_LO, 8'hFF, 8'hFF);
        rd_chk(12'hF65, 8'hFF, 8'h00);
        bus_wr(SPS_ADDR_MODE, 8'hFF);
        rd_chk(SPS_ADDR_MODE, 8'hFF, 8'h3F);
        bus_wr(SPS_ADDR_STAT, 8'h0C);
        rd_chk(SPS_ADDR_STAT, 8'hFF, 8'h01);
        bus_wr(SPS_ADDR_RATE_HI, 8'h12);
        bus_wr(SPS_ADDR_RATE_LO, 8'h34);
        bus_wr(SPS_ADDR_CTRL, 8'h03);
        bus_wr(SPS_ADDR_MODE, 8'h22);
        // live counter read while idle gives the reload value minus one
        rd_chk(SPS_ADDR_RATE_HI, 8'hFF, 8'h12);
        rd_chk(SPS_ADDR_RATE_LO, 8'hFF, 8'h33);
        bus_wr(SPS_ADDR_RATE_HI, 8'h00);
        bus_wr(SPS_ADDR_RATE_LO, 8'h00);
        rd_chk(SPS_ADDR_RATE_HI, 8'hFF, 8'hFF);
        rd_chk(SPS_ADDR_RATE_LO, 8'hFF, 8'hFF);
        bus_wr(SPS_ADDR_MODE, 8'h03);
        chk("ss_n_o high", 16'(ss_n_o), 16'h0001);
        bus_wr(SPS_ADDR_MODE, 8'h02);
        chk("ss_n_oe", 16'(ss_n_oe), 16'h0001);
        chk("ss_n_o low", 16'(ss_n_o), 16'h0000);
        rd_chk(SPS_ADDR_RATE_LO, 8'hFF, 8'h00);
        bus_wr(SPS_ADDR_RATE_LO, 8'h02);
        // one full byte, overrun attempt mid-flight
        r0 = rises;
        bus_wr(SPS_ADDR_DATA, 8'hA5);
        rd_chk(SPS_ADDR_STAT, 8'hFF, 8'h03);
        bus_rd(SPS_ADDR_LIVE_COUNTER_READBACK, v);
        chk("live_counter_readback zero bits", 16'(v & 8'h3C), 16'h0000);
        chk("live_counter_readback busy state", 16'(v[1:0] != 2'b00), 16'h0001);
        chk("live_counter_readback ticks", 16'(v[7:6]), 16'h0002);
        bus_wr(SPS_ADDR_DATA, 8'h5A);
        rd_chk(SPS_ADDR_STAT, 8'hFF, 8'h43);
        wait_idle();
        rd_chk(SPS_ADDR_STAT, 8'hFF, 8'hC1);
        rd_chk(SPS_ADDR_DATA, 8'hFF, 8'h3C);
        chk("far rx", 16'(far_rx), 16'h00A5);
        chk("sck period", 16'(period), 16'h0004);
        chk("bits", 16'(rises - r0), 16'h0008);
        bus_wr(SPS_ADDR_STAT, 8'h40);
        rd_chk(SPS_ADDR_STAT, 8'hFF, 8'h81);
        bus_wr(SPS_ADDR_STAT, 8'h80);
        rd_chk(SPS_ADDR_STAT, 8'hFF, 8'h01);
        // short characters, length codes 1 to 7
        for (n = 1; n < 8; n++) begin
            bus_wr(SPS_ADDR_MODE, 8'(8'h02 | (n << 2)));
            r0 = rises;
            bus_wr(SPS_ADDR_DATA, 8'hA5);
            wait_idle();
            chk("bits", 16'(rises - r0), 16'(n));
            chk("rx", 16'(far_rx & ((1 << n) - 1)),
                16'(8'hA5 >> (8 - n)));
            bus_wr(SPS_ADDR_STAT, 8'h80);
        end
        bus_wr(SPS_ADDR_MODE, 8'h02);
        bus_wr(SPS_ADDR_CTRL, 8'hC3);
        rd_chk(SPS_ADDR_STAT, 8'hFF, 8'h81);
        chk("irq_o", 16'(irq_o), 16'h0001);
        bus_wr(SPS_ADDR_STAT, 8'h80);
        rd_chk(SPS_ADDR_CTRL, 8'hFF, 8'h83);
        chk("irq_o off", 16'(irq_o), 16'h0000);
        // other master on the select line
        bus_wr(SPS_ADDR_MODE, 8'h00);
        tb_ss_n <= 1'b0;
        repeat (3) @(posedge clk);
        rd_chk(SPS_ADDR_STAT, 8'h20, 8'h20);
        tb_ss_n <= 1'b1;
        bus_wr(SPS_ADDR_STAT, 8'h20);
        rd_chk(SPS_ADDR_STAT, 8'h20, 8'h00);
        bus_wr(SPS_ADDR_CTRL, 8'h43);
        bus_wr(SPS_ADDR_CTRL, 8'h00);
        rd_chk(SPS_ADDR_STAT, 8'hFF, 8'h01);
        // divider as timer while disabled
        bus_wr(SPS_ADDR_RATE_LO, 8'h03);
        r0 = ipulses;
        bus_wr(SPS_ADDR_CTRL, 8'h20);
        for (i = 0; i < 200 && ipulses < r0 + 3; i++) @(posedge clk);
        if (ipulses < r0 + 3) begin
            chk("timer pulses", 16'(ipulses - r0), 16'h0003);
            wrap_up();
        end
        chk("timer gap", 16'(igap), 16'h0003);
        rd_chk(SPS_ADDR_STAT, 8'hFF, 8'h01);
        // slave, select dropped mid-character
        bus_wr(SPS_ADDR_MODE, 8'h02);
        bus_wr(SPS_ADDR_CTRL, 8'h01);
        chk("ss_n_oe slave", 16'(ss_n_oe), 16'h0000);
        bus_wr(SPS_ADDR_DATA, 8'h80);
        tb_ss_n <= 1'b0;
        repeat (4) @(posedge clk);
        rd_chk(SPS_ADDR_STAT, 8'h01, 8'h00);
        tb_sck <= 1'b1;
        repeat (8) @(posedge clk);
        tb_sck <= 1'b0;
        repeat (8) @(posedge clk);
        tb_ss_n <= 1'b1;
        repeat (4) @(posedge clk);
        rd_chk(SPS_ADDR_STAT, 8'hFF, 8'h91);
        tb_ss_n <= 1'b0;
        repeat (4) @(posedge clk);
        chk("miso restart", 16'(miso_o), 16'h0001);
        bus_wr(SPS_ADDR_STAT, 8'h90);
        rd_chk(SPS_ADDR_STAT, 8'h90, 8'h00);
        wrap_up();
    end
endmodule

`default_nettype wire
